// file: bench/jesd_lane_map_power_test_bench.sv
// bench: bus access, lane packing per mode, routing and power
`timescale 1ns/1ps
module jesd_lane_map_power_test_bench import lane_pkg::*;;
	logic hclk = 1'b0;
	logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, full_powerdown_pin = 1'b0;
	logic sample_valid = 1'b0, bnd = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic [BUS_W-1:0] ai = '0, aq = '0, bi = '0, bq = '0;
	logic [LINK_LANES*LANE_W-1:0] la, lb;
	logic [15:0] pwr, f_ok, f_early;
	logic hreadyout, hresp, frame_valid, sync_restart, pda, pdb;
	logic [4:0] m;
	int seed = 32'h26f8, fails = 0, n_compared = 0, t, i;
	always #25 hclk = ~hclk;
	lane_map_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .full_powerdown_pin, .sample_valid,
		.chan_a_i_samples(ai), .chan_a_q_samples(aq), .chan_b_i_samples(bi),
		.chan_b_q_samples(bq), .link_a_lane_data(la), .link_b_lane_data(lb),
		.lane_power_on(pwr), .frame_valid, .sync_restart, .chan_a_powerdown(pda),
		.chan_b_powerdown(pdb));
	link_receiver_model i_rx (.hclk, .hresetn, .sync_restart, .frame_valid,
		.frames_ok(f_ok), .frames_early(f_early));
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic ok, input string s);
		n_compared++;
		if (ok !== 1'b1) begin
			fails++;
			$display("mismatch at %0t: %s", $time, s);
		end
	endtask : chk
	// a used-up wait ends the run
	task automatic limit(input int n);
		if (n >= 100) begin
			fails++;
			end_of_test();
		end
	endtask : limit
	task automatic wait_ready();
		for (t = 0; t < 100; t++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				break;
		end
		limit(t);
	endtask : wait_ready
	// one single word transfer, read data left in q
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		q = hrdata;
	endtask : ahb
	task automatic run_wait();
		for (i = 0; i < 100; i++) begin
			ahb(1'b0, STATUS_ADDR, 32'h0);
			if (q[ST_RUN] === 1'b1)
				break;
		end
		limit(i);
	endtask : run_wait
	// reconfigure while disabled, then enable
	task automatic start(input logic [31:0] c);
		ahb(1'b1, CTRL_ADDR, c);
		ahb(1'b1, CTRL_ADDR, c | 32'h0100_0000);
		run_wait();
	endtask : start
	// one random frame in, wait for it at the lanes
	task automatic push();
		for (i = 0; i < 10; i++) begin
			ai[32*i +: 32] <= $random(seed);
			aq[32*i +: 32] <= $random(seed);
			bi[32*i +: 32] <= $random(seed);
			bq[32*i +: 32] <= $random(seed);
		end
		sample_valid <= 1'b1;
		@(posedge hclk);
		sample_valid <= 1'b0;
		for (i = 0; i < 100; i++) begin
			@(posedge hclk);
			if (frame_valid === 1'b1)
				break;
		end
		limit(i);
	endtask : push
	// expected lane word for link k, lane n
	function automatic logic [63:0] exp_lane(input int k, input int n);
		logic [BUS_W-1:0] xi, xq, si, sq, s;
		logic [63:0] r;
		int j;
		xi = bnd ? ai : bi;
		xq = bnd ? aq : bq;
		si = k == 1 ? xi : ai;
		sq = k == 1 ? xq : aq;
		s = n % 2 == 1 ? sq : si;
		r = '0;
		case (m)
			MODE_12: for (j = 0; j < 5; j++)
				r[63-12*j -: 12] = s[16*(n/2+4*j)+4 +: 12];
			MODE_13, MODE_16: if (n == 0)
				r[63:32] = {si[15:0], sq[15:0]} & 32'hfffe_fffe;
			MODE_14: if (n < 2)
				r[63:48] = s[15:0] & 16'hfffe;
			MODE_15: if (k == 0 && n == 0)
				r = {ai[15:0], aq[15:0], xi[15:0], xq[15:0]} & 64'hfffe_fffe_fffe_fffe;
			MODE_17: r[63:56] = ai[16*(2*n+k)+8 +: 8];
			MODE_18: r[63:56] = si[16*n+8 +: 8];
			default: r = '0;
		endcase
		return r;
	endfunction : exp_lane
	function automatic logic [15:0] exp_pwr(input logic [4:0] md);
		case (md)
			MODE_13, MODE_16: return 16'h0101;
			MODE_14: return 16'h0303;
			MODE_15: return 16'h0001;
			default: return 16'hffff;
		endcase
	endfunction : exp_pwr
	// main sequence
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, CTRL_ADDR, 32'h0);
		chk(q === CTRL_RESET, "ctrl reset");
		ahb(1'b1, 32'h0000_0008, 32'hffff_ffff);
		ahb(1'b0, 32'h0000_0008, 32'h0);
		chk(q === 32'h0, "unmapped read");
		ahb(1'b0, STATUS_ADDR, 32'h0);
		chk(q[31:16] === 16'hffff, "reset power");
		for (int b = 0; b < 2; b++) begin
			bnd = b[0];
			for (m = MODE_12; m <= MODE_18; m++) begin
				start({27'h0, m} | (bnd ? 32'h20 : 32'h0));
				push();
				for (i = 0; i < 8; i++) begin
					chk(la[64*i +: 64] === exp_lane(0, i), "link a lane");
					chk(lb[64*i +: 64] === exp_lane(1, i), "link b lane");
				end
				chk(pwr === exp_pwr(m), "lane power");
				$display("mode %0d bind %0d done", m, bnd);
			end
		end
		bnd = 1'b0;
		start(32'h0000_100e);
		push();
		chk(la[63:0] === 64'h0001_0203_0405_0607, "ramp octets");
		chk(pwr === 16'h0303, "power in test mode");
		ahb(1'b1, CTRL_ADDR, 32'h0000_060d);
		repeat (4) @(posedge hclk);
		chk(pwr === 16'hffff, "keepalive power");
		chk(la[127:64] === {8{IDLE_PAT_A}} || la[127:64] === {8{IDLE_PAT_B}}, "toggle");
		ahb(1'b1, CTRL_ADDR, 32'h0000_0092);
		repeat (3) @(posedge hclk);
		chk(pwr === 16'hff00 && pda === 1'b1, "channel a down");
		ahb(1'b1, CTRL_ADDR, 32'h0000_0132);
		repeat (3) @(posedge hclk);
		chk(pwr === 16'h00ff && pdb === 1'b1, "bound, b down");
		ahb(1'b1, CTRL_ADDR, 32'h0002_0012);
		repeat (3) @(posedge hclk);
		chk(pwr === 16'h0000, "power mode two");
		ahb(1'b1, CTRL_ADDR, 32'h0001_0012);
		repeat (3) @(posedge hclk);
		chk(pwr === 16'hffff, "power mode one");
		start(32'h0000_0012);
		full_powerdown_pin <= 1'b1;
		repeat (3) @(posedge hclk);
		chk(pwr === 16'h0000 && pda === 1'b1 && pdb === 1'b1, "pin down");
		full_powerdown_pin <= 1'b0;
		for (t = 0; t < 100; t++) begin
			@(posedge hclk);
			if (sync_restart === 1'b1)
				break;
		end
		limit(t);
		run_wait();
		push();
		chk(f_early === 16'h0 && f_ok !== 16'h0, "receiver frames");
		$display("power tests done");
		end_of_test();
	end
endmodule : jesd_lane_map_power_test_bench

// file: bench/lane_map_checker.sv
// port assertions for the lane block
`timescale 1ns/1ps
module lane_map_checker import lane_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic full_powerdown_pin,
	input wire logic sample_valid,
	input wire logic [ALL_LANES-1:0] lane_power_on,
	input wire logic frame_valid,
	input wire logic sync_restart,
	input wire logic chan_a_powerdown,
	input wire logic chan_b_powerdown
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic [CNT_W-1:0] gap_reg;
	// counts down the flush window after each restart
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			gap_reg <= '0;
		else if (sync_restart)
			gap_reg <= FLUSH_LAST;
		else if (gap_reg != '0)
			gap_reg <= gap_reg - CNT_ONE;
	end
	a_bus_ready: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("error response");
	a_pin_lanes_off: assert property (full_powerdown_pin |=> lane_power_on == '0)
		else $error("lanes powered while pin high");
	a_pin_chans_off: assert property (full_powerdown_pin |=> chan_a_powerdown && chan_b_powerdown)
		else $error("channels up while pin high");
	a_sync_single: assert property (sync_restart |=> !sync_restart)
		else $error("restart pulse too long");
	a_flush_quiet: assert property (frame_valid |-> gap_reg == '0)
		else $error("frame inside flush window");
	a_frame_cause: assert property (frame_valid |-> $past(sample_valid))
		else $error("frame without input");
	a_pd_a_lanes: assert property (chan_a_powerdown && $past(chan_a_powerdown) |-> lane_power_on[7:0] == '0)
		else $error("link a lanes up with channel a down");
	a_pd_b_lanes: assert property (chan_b_powerdown && $past(chan_b_powerdown) |-> lane_power_on[15:8] == '0)
		else $error("link b lanes up with channel b down");
	c_restart: cover property (sync_restart);
	c_frame: cover property (frame_valid);
	c_pin_off: cover property (full_powerdown_pin ##1 lane_power_on == '0);
endmodule : lane_map_checker

bind lane_map_top lane_map_checker i_chk (.hclk, .hresetn, .hreadyout, .hresp,
	.full_powerdown_pin, .sample_valid, .lane_power_on, .frame_valid, .sync_restart,
	.chan_a_powerdown, .chan_b_powerdown);

// file: bench/link_receiver_model.sv
// receiver model: discards frames until the flush time has passed
`timescale 1ns/1ps
module link_receiver_model import lane_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sync_restart,
	input wire logic frame_valid,
	output logic [15:0] frames_ok,
	output logic [15:0] frames_early
);
	logic [CNT_W-1:0] wait_reg;
	// stale pipeline data counts as early, the rest as good
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_reg <= '0;
			frames_ok <= '0;
			frames_early <= '0;
		end else begin
			if (sync_restart)
				wait_reg <= FLUSH_LAST;
			else if (wait_reg != '0)
				wait_reg <= wait_reg - CNT_ONE;
			if (frame_valid && wait_reg != '0)
				frames_early <= frames_early + 16'h0001;
			else if (frame_valid)
				frames_ok <= frames_ok + 16'h0001;
		end
	end
endmodule : link_receiver_model

// file: rtl/lane_map_top.sv
// lane packing, routing, serializer power and test select behind an AHB-Lite slave
//
// Notes on behaviour
// - mode 12 puts I and Q on alternate lanes, five 12-bit samples plus tail.
// - mode 13 sends I then Q on lane 0 of each link.
// - mode 14 sends one sample per lane: A I, A Q, B I, B Q.
// - mode 15 sends A I, A Q, B I, B Q on link A lane 0.
// - mode 16 sends I then Q on lane 0 of each link.
// - mode 17 puts even samples on link A, odd on link B.
// - mode 18 puts channel A on link A, channel B on link B.
// - a binding bit routes one channel into the lane mappers of both links.
// - the unused channel can then be powered down by its bit.
// - a binding bit sends one channel over both links.
// - binding is ignored in the single-channel mode.
// - the full power-down pin disables every serial output driver.
// - after power-down the link restarts and data waits out a flush time.
// - power mode above one, or the pin, powers down all serializers.
// - a channel power-down bit powers that channel and its link lanes down.
// - lanes above those the mode uses are powered down.
// - both keepalive bits keep spare lanes powered and toggling.
// - the test pattern select field picks the active test mode.
// - lane power follows the lane mode and power controls, never the test mode.
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module lane_map_top import lane_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic full_powerdown_pin,
	input wire logic sample_valid,
	input wire logic [BUS_W-1:0] chan_a_i_samples,
	input wire logic [BUS_W-1:0] chan_a_q_samples,
	input wire logic [BUS_W-1:0] chan_b_i_samples,
	input wire logic [BUS_W-1:0] chan_b_q_samples,
	output logic [LINK_LANES*LANE_W-1:0] link_a_lane_data,
	output logic [LINK_LANES*LANE_W-1:0] link_b_lane_data,
	output logic [ALL_LANES-1:0] lane_power_on,
	output logic frame_valid,
	output logic sync_restart,
	output logic chan_a_powerdown,
	output logic chan_b_powerdown
);
	// bus slave state
	logic wr_pend_reg;
	logic [ADDR_W-1:0] wr_addr_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [31:0] hrdata_reg;
	logic hreadyout_reg;
	wire [31:0] status_word;

	// settings in force, loaded only while the link is down
	logic [MODE_W-1:0] act_mode_reg;
	logic act_bind_a_reg;
	logic act_bind_b_reg;
	logic act_pd_a_reg;
	logic act_pd_b_reg;
	logic [TEST_W-1:0] act_test_reg;

	// link sequencing
	link_state_type state_reg;
	link_state_type state_next;
	logic [CNT_W-1:0] flush_cnt_reg;
	logic [CNT_W-1:0] flush_cnt_next;
	logic sync_restart_reg;
	logic frame_valid_reg;
	logic toggle_reg;
	logic [OCTET_W-1:0] ramp_reg;
	logic chan_a_pd_reg;
	logic chan_b_pd_reg;

	// lane outputs
	logic [ALL_LANES*LANE_W-1:0] lanes_reg;
	logic [ALL_LANES-1:0] lane_pwr_reg;
	wire [ALL_LANES*LANE_W-1:0] lanes_next;
	wire [ALL_LANES-1:0] lane_pwr_next;
	wire [ALL_LANES-1:0] lane_used;
	wire [ALL_LANES*LANE_W-1:0] mapped;

	// address phase decode
	wire addr_take = hsel & hready & htrans[TRANS_ACTIVE_BIT];
	wire rd_take = addr_take & ~hwrite;
	wire [ADDR_W-1:0] rd_addr = haddr[ADDR_W-1:0];
	wire rd_hit_ctrl = (haddr[31:ADDR_W] == '0) && (rd_addr == CTRL_ADDR);
	wire rd_hit_status = (haddr[31:ADDR_W] == '0) && (rd_addr == STATUS_ADDR);
	wire [31:0] rd_next = rd_hit_ctrl ? ctrl_reg : rd_hit_status ? status_word : 32'h0000_0000;
	wire ctrl_wr = wr_pend_reg && (wr_addr_reg == CTRL_ADDR);

	// control register write, reserved bits kept clear
	assign ctrl_next = ctrl_wr ? (hwdata & CTRL_WMASK) : ctrl_reg;

	// fields that software writes
	wire [MODE_W-1:0] sh_mode = ctrl_reg[CTRL_MODE_LSB +: MODE_W];
	wire [TEST_W-1:0] sh_test = ctrl_reg[CTRL_TEST_LSB +: TEST_W];
	wire [PWR_W-1:0] power_mode = ctrl_reg[CTRL_PWR_LSB +: PWR_W];
	wire link_enable = ctrl_reg[CTRL_LINK_EN];
	wire keep_all = ctrl_reg[CTRL_KEEP_A] & ctrl_reg[CTRL_KEEP_B];

	// mode checks and binding
	wire mode_ok = (act_mode_reg >= MODE_12) && (act_mode_reg <= MODE_18);
	wire single_mode = (act_mode_reg == MODE_17);
	wire bind_a_eff = act_bind_a_reg & ~single_mode;
	wire bind_b_eff = act_bind_b_reg & ~single_mode & ~bind_a_eff;

	// source of each link after binding
	wire [BUS_W-1:0] src_a_i = bind_b_eff ? chan_b_i_samples : chan_a_i_samples;
	wire [BUS_W-1:0] src_a_q = bind_b_eff ? chan_b_q_samples : chan_a_q_samples;
	wire [BUS_W-1:0] src_b_i = bind_a_eff ? chan_a_i_samples : chan_b_i_samples;
	wire [BUS_W-1:0] src_b_q = bind_a_eff ? chan_a_q_samples : chan_b_q_samples;

	// serializers all off for the pin or a power mode above one
	wire ser_down = full_powerdown_pin | (power_mode > PWR_MODE_MAX);

	// test and keepalive octets
	wire ramp_on = (act_test_reg == TEST_RAMP);
	wire [OCTET_W-1:0] idle_octet = toggle_reg ? IDLE_PAT_A : IDLE_PAT_B;
	wire [LANE_W-1:0] idle_word = {OCTETS{idle_octet}};
	wire [LANE_W-1:0] ramp_word;
	wire run = (state_reg == LS_RUN);

	// ramp octets count up across the frame
	genvar k;
	for (k = 0; k < OCTETS; k++) begin : g_ramp
		assign ramp_word[LANE_W-1-OCTET_W*k -: OCTET_W] = ramp_reg + OCTET_W'(k);
	end

	// per lane mapping, power and output select
	genvar g;
	for (g = 0; g < ALL_LANES; g++) begin : g_lane
		localparam int LK = g / LINK_LANES;
		localparam int LN = g % LINK_LANES;
		wire chan_pd = (LK == 0) ? act_pd_a_reg : act_pd_b_reg;

		lane_mapper #(
			.LINK(LK),
			.LANE(LN)
		) u_map (
			.mode(act_mode_reg),
			.own_i((LK == 0) ? src_a_i : src_b_i),
			.own_q((LK == 0) ? src_a_q : src_b_q),
			.far_i(src_b_i[SAMPLE_W-1:0]),
			.far_q(src_b_q[SAMPLE_W-1:0]),
			.single_bus(chan_a_i_samples),
			.lane_word(mapped[g*LANE_W +: LANE_W]),
			.lane_used(lane_used[g])
		);

		// power by lane mode and power controls only, not test mode
		assign lane_pwr_next[g] = ~ser_down & ~chan_pd & mode_ok & (lane_used[g] | keep_all);

		// dark lanes zero, spare lanes toggle, live lanes carry data
		assign lanes_next[g*LANE_W +: LANE_W] =
			!lane_pwr_next[g] ? '0 :
			!lane_used[g] ? idle_word :
			!run ? '0 :
			ramp_on ? ramp_word : mapped[g*LANE_W +: LANE_W];
	end

	// status readback
	assign status_word[ST_MODE_LSB +: MODE_W] = act_mode_reg;
	assign status_word[ST_MODE_OK] = mode_ok;
	assign status_word[ST_SER_DOWN] = ser_down;
	assign status_word[ST_FLUSH] = (state_reg == LS_FLUSH);
	assign status_word[ST_RUN] = run;
	assign status_word[ST_LANES_LSB-1:ST_RUN+1] = '0;
	assign status_word[31:ST_LANES_LSB] = lane_pwr_reg;

	// link sequence: down, flush, run
	always_comb begin
		state_next = state_reg;
		flush_cnt_next = flush_cnt_reg;
		case (state_reg)
			LS_DOWN: begin
				flush_cnt_next = '0;
				if (link_enable && !ser_down && mode_ok) begin
					state_next = LS_FLUSH;
				end
			end
			LS_FLUSH: begin
				flush_cnt_next = flush_cnt_reg + CNT_ONE;
				if (!link_enable || ser_down) begin
					state_next = LS_DOWN;
				end else if (flush_cnt_reg == FLUSH_LAST) begin
					state_next = LS_RUN;
				end
			end
			LS_RUN: begin
				if (!link_enable || ser_down) begin
					state_next = LS_DOWN;
				end
			end
			default: begin
				state_next = LS_DOWN;
			end
		endcase
	end

	// bus slave flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
			ctrl_reg <= CTRL_RESET;
			hrdata_reg <= '0;
			hreadyout_reg <= 1'b1;
		end else begin
			wr_pend_reg <= addr_take & hwrite;
			if (addr_take) begin
				wr_addr_reg <= haddr[ADDR_W-1:0];
			end
			ctrl_reg <= ctrl_next;
			if (rd_take) begin
				hrdata_reg <= rd_next;
			end
			hreadyout_reg <= 1'b1;
		end
	end

	// settings take effect only while the link is down
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_mode_reg <= CTRL_RESET[CTRL_MODE_LSB +: MODE_W];
			act_bind_a_reg <= 1'b0;
			act_bind_b_reg <= 1'b0;
			act_pd_a_reg <= 1'b0;
			act_pd_b_reg <= 1'b0;
			act_test_reg <= TEST_OFF;
		end else if (state_reg == LS_DOWN) begin
			act_mode_reg <= sh_mode;
			act_bind_a_reg <= ctrl_reg[CTRL_BIND_A];
			act_bind_b_reg <= ctrl_reg[CTRL_BIND_B];
			act_pd_a_reg <= ctrl_reg[CTRL_PD_A];
			act_pd_b_reg <= ctrl_reg[CTRL_PD_B];
			act_test_reg <= sh_test;
		end
	end

	// sequencer, restart pulse, frame flag, toggle and ramp
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= LS_DOWN;
			flush_cnt_reg <= '0;
			sync_restart_reg <= 1'b0;
			frame_valid_reg <= 1'b0;
			toggle_reg <= 1'b0;
			ramp_reg <= '0;
		end else begin
			state_reg <= state_next;
			flush_cnt_reg <= flush_cnt_next;
			sync_restart_reg <= (state_reg == LS_DOWN) && (state_next == LS_FLUSH);
			frame_valid_reg <= run & sample_valid;
			toggle_reg <= ~toggle_reg;
			if (run && sample_valid) begin
				ramp_reg <= ramp_reg + RAMP_STEP;
			end else if (!run) begin
				ramp_reg <= '0;
			end
		end
	end

	// lane data, lane power and channel power-down outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lanes_reg <= '0;
			lane_pwr_reg <= '0;
			chan_a_pd_reg <= 1'b0;
			chan_b_pd_reg <= 1'b0;
		end else begin
			lanes_reg <= lanes_next;
			lane_pwr_reg <= lane_pwr_next;
			chan_a_pd_reg <= act_pd_a_reg | full_powerdown_pin;
			chan_b_pd_reg <= act_pd_b_reg | full_powerdown_pin;
		end
	end

	// outputs straight from flops, hresp tied low
	assign hrdata = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = 1'b0;
	assign link_a_lane_data = lanes_reg[LINK_LANES*LANE_W-1:0];
	assign link_b_lane_data = lanes_reg[ALL_LANES*LANE_W-1:LINK_LANES*LANE_W];
	assign lane_power_on = lane_pwr_reg;
	assign frame_valid = frame_valid_reg;
	assign sync_restart = sync_restart_reg;
	assign chan_a_powerdown = chan_a_pd_reg;
	assign chan_b_powerdown = chan_b_pd_reg;
endmodule : lane_map_top

// file: rtl/lane_mapper.sv
// one lane's frame word, built from the samples feeding its link
`timescale 1ns/1ps
module lane_mapper import lane_pkg::*; #(
	parameter int LINK = 0,
	parameter int LANE = 0
) (
	input wire logic [MODE_W-1:0] mode,
	input wire logic [BUS_W-1:0] own_i,
	input wire logic [BUS_W-1:0] own_q,
	input wire logic [SAMPLE_W-1:0] far_i,
	input wire logic [SAMPLE_W-1:0] far_q,
	input wire logic [BUS_W-1:0] single_bus,
	output logic [LANE_W-1:0] lane_word,
	output logic lane_used
);
	localparam int PICK = LANE / 2;
	localparam int SINGLE_IDX = 2 * LANE + LINK;
	localparam int ZW = LANE_W - 2 * SAMPLE_W;

	// even lanes carry in-phase, odd lanes quadrature
	wire [BUS_W-1:0] m12_src = (LANE % 2 == 0) ? own_i : own_q;
	wire [LANE_W-TAIL_W-1:0] m12_body;
	wire [SAMPLE_W-1:0] i0 = fld15(own_i[SAMPLE_W-1:0]);
	wire [SAMPLE_W-1:0] q0 = fld15(own_q[SAMPLE_W-1:0]);
	wire [W8-1:0] dual8 = own_i[LANE*SAMPLE_W+SAMPLE_W-1 -: W8];
	wire [W8-1:0] single8 = single_bus[SINGLE_IDX*SAMPLE_W+SAMPLE_W-1 -: W8];

	// five 12-bit samples, stepping four samples per slot
	genvar j;
	for (j = 0; j < SLOTS12; j++) begin : g_slot
		assign m12_body[LANE_W-TAIL_W-1-W12*j -: W12] =
			m12_src[(PICK+GROUP12*j)*SAMPLE_W+SAMPLE_W-1 -: W12];
	end

	// pack by mode; unused lanes give zero
	always_comb begin
		lane_word = '0;
		lane_used = 1'b0;
		case (mode)
			MODE_12: begin
				lane_word = {m12_body, {TAIL_W{1'b0}}};
				lane_used = 1'b1;
			end
			MODE_13, MODE_16: begin
				if (LANE == 0) begin
					lane_word = {i0, q0, {ZW{1'b0}}};
					lane_used = 1'b1;
				end
			end
			MODE_14: begin
				if (LANE < 2) begin
					lane_word = {(LANE == 0) ? i0 : q0, {(LANE_W-SAMPLE_W){1'b0}}};
					lane_used = 1'b1;
				end
			end
			MODE_15: begin
				if (LINK == 0 && LANE == 0) begin
					lane_word = {i0, q0, fld15(far_i), fld15(far_q)};
					lane_used = 1'b1;
				end
			end
			MODE_17: begin
				lane_word = {single8, {(LANE_W-W8){1'b0}}};
				lane_used = 1'b1;
			end
			MODE_18: begin
				lane_word = {dual8, {(LANE_W-W8){1'b0}}};
				lane_used = 1'b1;
			end
			default: begin
				lane_word = '0;
				lane_used = 1'b0;
			end
		endcase
	end
endmodule : lane_mapper

// file: rtl/lane_pkg.sv
// constants, register layout and types for the lane mapping block
package lane_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int FLUSH_TIME_NS = 1000;
	localparam int FLUSH_CYCLES = (FLUSH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] FLUSH_LAST = CNT_W'(FLUSH_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

	// sample and lane geometry
	localparam int SAMPLE_W = 16;
	localparam int SAMPLE_WORDS = 20;
	localparam int BUS_W = SAMPLE_W * SAMPLE_WORDS;
	localparam int LANE_W = 64;
	localparam int OCTET_W = 8;
	localparam int OCTETS = LANE_W / OCTET_W;
	localparam int LINK_LANES = 8;
	localparam int ALL_LANES = 16;
	localparam int W12 = 12;
	localparam int W8 = 8;
	localparam int TAIL_W = 4;
	localparam int GROUP12 = 4;
	localparam int SLOTS12 = 5;

	// lane modes handled here
	localparam int MODE_W = 5;
	localparam logic [MODE_W-1:0] MODE_12 = 5'h0c;
	localparam logic [MODE_W-1:0] MODE_13 = 5'h0d;
	localparam logic [MODE_W-1:0] MODE_14 = 5'h0e;
	localparam logic [MODE_W-1:0] MODE_15 = 5'h0f;
	localparam logic [MODE_W-1:0] MODE_16 = 5'h10;
	localparam logic [MODE_W-1:0] MODE_17 = 5'h11;
	localparam logic [MODE_W-1:0] MODE_18 = 5'h12;

	// power mode and test patterns
	localparam int PWR_W = 8;
	localparam logic [PWR_W-1:0] PWR_MODE_MAX = 8'h01;
	localparam int TEST_W = 4;
	localparam logic [TEST_W-1:0] TEST_OFF = 4'h0;
	localparam logic [TEST_W-1:0] TEST_RAMP = 4'h1;
	localparam logic [OCTET_W-1:0] IDLE_PAT_A = 8'haa;
	localparam logic [OCTET_W-1:0] IDLE_PAT_B = 8'h55;
	localparam logic [OCTET_W-1:0] RAMP_STEP = 8'h08;

	// register map
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
	localparam int TRANS_ACTIVE_BIT = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_000c;
	localparam logic [31:0] CTRL_WMASK = 32'h01ff_f7ff;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_BIND_A = 5;
	localparam int CTRL_BIND_B = 6;
	localparam int CTRL_PD_A = 7;
	localparam int CTRL_PD_B = 8;
	localparam int CTRL_KEEP_A = 9;
	localparam int CTRL_KEEP_B = 10;
	localparam int CTRL_TEST_LSB = 12;
	localparam int CTRL_PWR_LSB = 16;
	localparam int CTRL_LINK_EN = 24;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_MODE_OK = 5;
	localparam int ST_SER_DOWN = 6;
	localparam int ST_FLUSH = 7;
	localparam int ST_RUN = 8;
	localparam int ST_LANES_LSB = 16;

	typedef enum logic [2:0] {
		LS_DOWN = 3'b001,
		LS_FLUSH = 3'b010,
		LS_RUN = 3'b100
	} link_state_type;

	// 15-bit sample in a two-octet field, low bit left clear
	function automatic logic [SAMPLE_W-1:0] fld15(input logic [SAMPLE_W-1:0] w);
		fld15 = {w[SAMPLE_W-1:1], 1'b0};
	endfunction : fld15
endpackage : lane_pkg
